// ===== pkg/prc_map.svh
`ifndef PRC_MAP_SVH
`define PRC_MAP_SVH
// Register byte offsets
`define PRC_OFS_CTRL      8'h00
`define PRC_OFS_CORR      8'h04
`define PRC_OFS_STAT      8'h08
// Control register fields
`define PRC_CTRL_EDGE_LO  0
`define PRC_CTRL_EDGE_HI  1
`define PRC_CTRL_RST_LO   2
`define PRC_CTRL_RST_HI   4
`define PRC_CTRL_ASEL_LO  5
`define PRC_CTRL_ASEL_HI  6
`define PRC_CTRL_RESET    32'h0000_0000
// Correction register fields
`define PRC_CORR_ODD_LO   0
`define PRC_CORR_SRC_LO   8
`define PRC_CORR_RESET    32'h0000_0000
// Edge select codes
`define PRC_EDGE_DIRECT   2'h0
`define PRC_EDGE_RISE     2'h1
`define PRC_EDGE_FALL     2'h2
`define PRC_EDGE_BOTH     2'h3
// Reload A source codes
`define PRC_ASEL_OFF      2'h0
`define PRC_ASEL_A        2'h1
`define PRC_ASEL_B        2'h2
`define PRC_ASEL_C        2'h3
`endif

// ===== pkg/prc_pkg.sv
package prc_pkg;
    // Correction source per pair
    typedef enum logic [1:0] {
        PRC_SRC_BIT_type_v  = 2'h0,
        PRC_SRC_SENSE_v     = 2'h1,
        PRC_SRC_SENSE2_v    = 2'h2,
        PRC_SRC_DIR_v       = 2'h3
    } prc_src_type;
    // Bus slave states
    typedef enum logic [2:0] {
        PRC_BUS_IDLE = 3'b001,
        PRC_BUS_ACK  = 3'b010,
        PRC_BUS_WAIT = 3'b100
    } prc_bus_type;
endpackage

// ===== rtl/prc_edge_detect.sv
`timescale 1ns/100ps
`include "prc_map.svh"
// Synchroniser and edge qualifier for the commutation event
module prc_edge_detect (
    input  wire logic       clk_sys,
    input  wire logic       sys_rst,
    input  wire logic       eventIn,
    input  wire logic [1:0] edgeSel,
    output logic            eventHit
);
    logic syncA;
    logic syncB;
    logic syncPrev;

    // Two stages; only syncB and its delayed copy syncPrev are looked at
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            syncA    <= 1'b0;
            syncB    <= 1'b0;
            syncPrev <= 1'b0;
        end else begin
            syncA    <= eventIn;
            syncB    <= syncA;
            syncPrev <= syncB;
        end
    end

    // Edge qualification per selected code
    always_comb begin
        case (edgeSel)
            `PRC_EDGE_DIRECT: eventHit = syncB;
            `PRC_EDGE_RISE:   eventHit = syncB & ~syncPrev;
            `PRC_EDGE_FALL:   eventHit = ~syncB & syncPrev;
            default:          eventHit = syncB ^ syncPrev;
        endcase
    end

    // Judged against the pin itself, so a short synchroniser is caught too
    chk_rise_edge: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (edgeSel == `PRC_EDGE_RISE && eventHit) |-> ($past(eventIn, 2) && !$past(eventIn, 3)))
        else $error("rise edge qualifier wrong");
endmodule

// ===== rtl/prc_pair_select.sv
`timescale 1ns/100ps
`include "prc_map.svh"
// Odd/even pulse value selection for each complementary pair
module prc_pair_select #(
    parameter int PAIRS = 3
) (
    input  wire logic [PAIRS-1:0]   senseIn,
    input  wire logic [PAIRS-1:0]   oddEvenBit,
    input  wire logic [2*PAIRS-1:0] srcSel,
    input  wire logic [PAIRS-1:0]   countDown,
    output logic      [PAIRS-1:0]   useOdd
);
    initial begin
        if (PAIRS < 1 || PAIRS > 8) $error("PAIRS out of range");
    end

    // One selector per pair; mixed source codes use the sense input
    genvar i;
    generate
        for (i = 0; i < PAIRS; i = i + 1) begin : gPair
            always_comb begin
                case (srcSel[2*i +: 2])
                    2'h0:    useOdd[i] = oddEvenBit[i];
                    2'h3:    useOdd[i] = countDown[i];
                    default: useOdd[i] = ~senseIn[i];
                endcase
            end
        end
    endgenerate
endmodule

// ===== rtl/prc_reload_unit.sv
`timescale 1ns/100ps
`include "prc_map.svh"
// What this block does
// - Edge code picks level, rise, fall, both
// - Restart makes commutation reload plus qualifier
// - One reload pulse per cycle end or restart event, merged when both coincide
// - B,C fixed; A off until programmed
// - Qualifier accompanies async reload A exactly
// - Coinciding normal reload suppresses the qualifier
// - Exactly one value register drives each pair
// - Sense input can choose active register
// - Source zeros: odd/even bit chooses
// - Source ones: counting direction chooses
module prc_reload_unit #(
    parameter int PAIRS = 3
) (
    input  wire logic               clk_sys,
    input  wire logic               sys_rst,
    input  wire logic [31:0]        wb_adr_i,
    input  wire logic [31:0]        wb_dat_i,
    input  wire logic [3:0]         wb_sel_i,
    input  wire logic               wb_we_i,
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    output logic      [31:0]        wb_dat_o,
    output logic                    wb_ack_o,
    input  wire logic               commEvent,
    input  wire logic [2:0]         cycleEnd,
    input  wire logic [PAIRS-1:0]   currentSenseN,
    input  wire logic [PAIRS-1:0]   countDown,
    output logic                    reloadA,
    output logic                    reloadB,
    output logic                    reloadC,
    output logic                    reloadAsyncQualifier,
    output logic      [PAIRS-1:0]   useOddValue
);
    initial begin
        if (PAIRS < 1 || PAIRS > 8) $error("PAIRS out of range");
    end

    logic [31:0]         ctrlReg;
    logic [31:0]         corrReg;
    logic                eventHit;
    logic [2:0]          asyncHit;
    logic [2:0]          baseReload;
    logic [2:0]          baseAsync;
    logic                next_reloadA;
    logic                next_qual;
    logic [PAIRS-1:0]    selOdd;
    logic [PAIRS-1:0]    syncS1;
    logic [PAIRS-1:0]    syncS2;
    logic [PAIRS-1:0]    dirS1;
    logic [PAIRS-1:0]    dirS2;
    prc_pkg::prc_bus_type busState;

    logic [1:0] edgeSel;
    logic [2:0] restartEn;
    logic [1:0] aSel;
    assign edgeSel   = ctrlReg[`PRC_CTRL_EDGE_HI:`PRC_CTRL_EDGE_LO];
    assign restartEn = ctrlReg[`PRC_CTRL_RST_HI:`PRC_CTRL_RST_LO];
    assign aSel      = ctrlReg[`PRC_CTRL_ASEL_HI:`PRC_CTRL_ASEL_LO];

    prc_edge_detect uEdge (
        .clk_sys  (clk_sys),
        .sys_rst  (sys_rst),
        .eventIn  (commEvent),
        .edgeSel  (edgeSel),
        .eventHit (eventHit)
    );

    // Sense and direction come from pins, so they are synchronised too
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            syncS1 <= '0;
            syncS2 <= '0;
            dirS1  <= '0;
            dirS2  <= '0;
        end else begin
            syncS1 <= currentSenseN;
            syncS2 <= syncS1;
            dirS1  <= countDown;
            dirS2  <= dirS1;
        end
    end

    prc_pair_select #(.PAIRS(PAIRS)) uPair (
        .senseIn    (syncS2),
        .oddEvenBit (corrReg[`PRC_CORR_ODD_LO +: PAIRS]),
        .srcSel     (corrReg[`PRC_CORR_SRC_LO +: 2*PAIRS]),
        .countDown  (dirS2),
        .useOdd     (selOdd)
    );

    // Per time base: restart turns a commutation event into a reload
    assign asyncHit   = restartEn & {3{eventHit}};
    assign baseReload = cycleEnd | asyncHit;
    assign baseAsync  = asyncHit & ~cycleEnd;

    // Reload A routing; off until software picks a base
    always_comb begin
        case (aSel)
            `PRC_ASEL_A: begin
                next_reloadA = baseReload[0];
                next_qual    = baseAsync[0];
            end
            `PRC_ASEL_B: begin
                next_reloadA = baseReload[1];
                next_qual    = baseAsync[1];
            end
            `PRC_ASEL_C: begin
                next_reloadA = baseReload[2];
                next_qual    = baseAsync[2];
            end
            default: begin
                next_reloadA = 1'b0;
                next_qual    = 1'b0;
            end
        endcase
    end

    // Outputs registered so qualifier and reload share one edge
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            reloadA              <= 1'b0;
            reloadB              <= 1'b0;
            reloadC              <= 1'b0;
            reloadAsyncQualifier <= 1'b0;
        end else begin
            reloadA              <= next_reloadA;
            reloadB              <= baseReload[1];
            reloadC              <= baseReload[2];
            reloadAsyncQualifier <= next_qual;
        end
    end

    // One-hot selector registered: exactly one register per pair
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            useOddValue <= '0;
        end else begin
            useOddValue <= selOdd;
        end
    end

    // Wishbone slave: ack one cycle after request, then one idle cycle
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            busState <= prc_pkg::PRC_BUS_IDLE;
            wb_ack_o <= 1'b0;
        end else begin
            case (busState)
                prc_pkg::PRC_BUS_IDLE: begin
                    if (wb_cyc_i && wb_stb_i) begin
                        busState <= prc_pkg::PRC_BUS_ACK;
                        wb_ack_o <= 1'b1;
                    end
                end
                prc_pkg::PRC_BUS_ACK: begin
                    busState <= prc_pkg::PRC_BUS_WAIT;
                    wb_ack_o <= 1'b0;
                end
                prc_pkg::PRC_BUS_WAIT: begin
                    // Avoids acking a stale held request twice
                    if (!(wb_cyc_i && wb_stb_i)) begin
                        busState <= prc_pkg::PRC_BUS_IDLE;
                    end
                end
                default: begin
                    busState <= prc_pkg::PRC_BUS_IDLE;
                    wb_ack_o <= 1'b0;
                end
            endcase
        end
    end

    logic busWrite;
    assign busWrite = (busState == prc_pkg::PRC_BUS_IDLE) && wb_cyc_i && wb_stb_i && wb_we_i;

    // Register writes with byte lanes; write lands with the ack edge
    genvar b;
    generate
        for (b = 0; b < 4; b = b + 1) begin : gLane
            always_ff @(posedge clk_sys) begin
                if (sys_rst) begin
                    ctrlReg[8*b +: 8] <= 8'(`PRC_CTRL_RESET >> (8*b));
                    corrReg[8*b +: 8] <= 8'(`PRC_CORR_RESET >> (8*b));
                end else if (busWrite && wb_sel_i[b]) begin
                    if (wb_adr_i[7:0] == `PRC_OFS_CTRL) begin
                        ctrlReg[8*b +: 8] <= wb_dat_i[8*b +: 8];
                    end
                    if (wb_adr_i[7:0] == `PRC_OFS_CORR) begin
                        corrReg[8*b +: 8] <= wb_dat_i[8*b +: 8];
                    end
                end
            end
        end
    endgenerate

    // Read mux; unmapped offsets read zero, unused control bits too
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (busState == prc_pkg::PRC_BUS_IDLE && wb_cyc_i && wb_stb_i) begin
            case (wb_adr_i[7:0])
                `PRC_OFS_CTRL: wb_dat_o <= {25'h0, ctrlReg[6:0]};
                `PRC_OFS_CORR: wb_dat_o <= corrReg;
                `PRC_OFS_STAT: wb_dat_o <= 32'({syncS2, useOddValue});
                default:       wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    chk_qual_with_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        reloadAsyncQualifier |-> reloadA)
        else $error("qualifier without reload A");
    chk_coincide_supp: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (aSel == `PRC_ASEL_B && cycleEnd[1]) |=> !reloadAsyncQualifier)
        else $error("qualifier on coinciding reload");
    chk_restart_both: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (eventHit && restartEn[1] && !cycleEnd[1] && aSel == `PRC_ASEL_B)
        |=> (reloadA && reloadAsyncQualifier))
        else $error("restart did not give both");
    chk_cycle_pulse: assert property (@(posedge clk_sys) disable iff (sys_rst)
        cycleEnd[2] |=> reloadC)
        else $error("missing reload C");
    chk_a_off: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ($past(aSel) == `PRC_ASEL_OFF) |-> !reloadA)
        else $error("reload A active while off");
    chk_no_restart: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (restartEn == 3'h0) |=> !reloadAsyncQualifier)
        else $error("qualifier without restart");
    chk_dir_select: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (corrReg[`PRC_CORR_SRC_LO +: 2] == 2'h3) |=> (useOddValue[0] == $past(dirS2[0])))
        else $error("direction select wrong");
    chk_bit_select: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (corrReg[`PRC_CORR_SRC_LO +: 2] == 2'h0) |=> (useOddValue[0] == $past(corrReg[0])))
        else $error("odd even bit select wrong");
    chk_ack_once: assert property (@(posedge clk_sys) disable iff (sys_rst)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");
endmodule

// ===== bench/prc_far_model.sv
`timescale 1ns/100ps
// Far side: control-cycle timer of bases A..C and the trigger consumers
module prc_far_model #(
    parameter int PERIOD = 8
) (
    input  wire logic       clk_sys,
    input  wire logic       sys_rst,
    input  wire logic [2:0] baseEn,
    input  wire logic       reloadA,
    input  wire logic       reloadB,
    input  wire logic       reloadC,
    input  wire logic       reloadAsyncQualifier,
    output logic      [2:0] cycleEnd,
    output int              cnt [0:4]
);
    int         phase;
    logic [4:0] hit;
    // Slot 4 counts a qualifier seen without reload A, which must never happen
    assign hit = {reloadAsyncQualifier & ~reloadA, reloadAsyncQualifier, reloadC, reloadB, reloadA};
    // Free-running cycle; baseEn picks the bases, one at a time where they must be told apart
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            phase <= 0;
            cycleEnd <= 3'h0;
        end else begin
            phase <= (phase == PERIOD - 1) ? 0 : phase + 1;
            cycleEnd <= baseEn & {3{phase == PERIOD - 1}};
        end
    end
    // Consumers only count triggers; the bench judges the deltas
    always_ff @(posedge clk_sys) begin
        for (int i = 0; i < 5; i++) begin
            cnt[i] <= sys_rst ? 0 : cnt[i] + int'(hit[i]);
        end
    end
endmodule

// ===== bench/prc_reload_unit_tb.sv
`timescale 1ns/100ps
`define CHK(g, e) begin \
    compares++; \
    if ((g) !== (e)) begin \
        failures++; \
        $display("unexpected at %0t: got %0h expected %0h", $time, g, e); \
    end \
end
module prc_reload_unit_tb;
    localparam int PERIOD = 8;
    logic        clk_sys = 1'b0;
    logic        sys_rst = 1'b1;
    logic [31:0] wbAdr = 32'h0;
    logic [31:0] wbDatI = 32'h0;
    logic [3:0]  wbSel = 4'hF;
    logic        wbWe = 1'b0;
    logic        wbCyc = 1'b0;
    logic        wbStb = 1'b0;
    logic [31:0] wbDatO;
    logic        wbAck;
    logic        commEvent = 1'b0;
    logic [2:0]  cycleEnd;
    logic [2:0]  senseN = 3'h7;
    logic [2:0]  countDown = 3'h0;
    logic [2:0]  baseEn = 3'h0;
    logic        reloadA;
    logic        reloadB;
    logic        reloadC;
    logic        qual;
    logic [2:0]  useOdd;
    logic [31:0] rd;
    int          cnt [0:4];
    int          s0 [0:4];
    int          d [0:4];
    int          failures = 0;
    int          compares = 0;
    // Clock at 100 MHz
    always #5 clk_sys = ~clk_sys;
    // Block under test and its far side
    prc_reload_unit uut (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .wb_adr_i(wbAdr),
        .wb_dat_i(wbDatI),
        .wb_sel_i(wbSel),
        .wb_we_i(wbWe),
        .wb_cyc_i(wbCyc),
        .wb_stb_i(wbStb),
        .wb_dat_o(wbDatO),
        .wb_ack_o(wbAck),
        .commEvent(commEvent),
        .cycleEnd(cycleEnd),
        .currentSenseN(senseN),
        .countDown(countDown),
        .reloadA(reloadA),
        .reloadB(reloadB),
        .reloadC(reloadC),
        .reloadAsyncQualifier(qual),
        .useOddValue(useOdd)
    );
    prc_far_model #(.PERIOD(PERIOD)) far (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .baseEn(baseEn),
        .reloadA(reloadA),
        .reloadB(reloadB),
        .reloadC(reloadC),
        .reloadAsyncQualifier(qual),
        .cycleEnd(cycleEnd),
        .cnt(cnt)
    );
    // Counts and verdict
    task automatic summarize();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Single cycle; request held until ack is sampled, bounded wait
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] v);
        int n;
        n = 0;
        @(posedge clk_sys);
        wbAdr <= {24'h0, a};
        wbWe <= w;
        wbDatI <= v;
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (wbAck !== 1'b1 && n < 20);
        if (wbAck !== 1'b1) begin
            failures++;
            summarize();
        end else begin
            rd = wbDatO;
            wbCyc <= 1'b0;
            wbStb <= 1'b0;
            wbWe <= 1'b0;
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // Trigger counts over a window, after old pulses have drained
    task automatic diff();
        for (int i = 0; i < 5; i++) d[i] = cnt[i] - s0[i];
    endtask
    task automatic win(input int n);
        tick(PERIOD + 2);
        s0 = cnt;
        tick(n);
        diff();
    endtask
    task automatic testReset();
        xfer(8'h00, 1'b0, 32'h0);
        `CHK(rd, 32'h0)
        xfer(8'h0C, 1'b1, 32'hFFFF_FFFF);
        xfer(8'h0C, 1'b0, 32'h0);
        `CHK(rd, 32'h0)
        // Only the low byte lane may land
        wbSel <= 4'h1;
        xfer(8'h04, 1'b1, 32'h0000_3F07);
        wbSel <= 4'hF;
        xfer(8'h04, 1'b0, 32'h0);
        `CHK(rd, 32'h0000_0007)
        baseEn <= 3'h7;
        win(4 * PERIOD);
        `CHK(d[0], 0)
        `CHK(d[1], 4)
        `CHK(d[2], 4)
        $display("test reset done");
    endtask
    task automatic testSource();
        for (int s = 1; s < 4; s++) begin
            xfer(8'h00, 1'b1, 32'(s) << 5);
            for (int b = 0; b < 3; b++) begin
                baseEn <= 3'(1 << b);
                win(4 * PERIOD);
                `CHK(d[0], (b == s - 1) ? 4 : 0)
                `CHK(d[1], (b == 1) ? 4 : 0)
            end
        end
        $display("test source done");
    endtask
    // Level, rise, fall, both, then rise with restart off
    task automatic testEdge();
        logic [31:0] ctl [0:4] = '{32'h24, 32'h25, 32'h26, 32'h27, 32'h21};
        int          ex [0:4] = '{6, 1, 1, 2, 0};
        baseEn <= 3'h0;
        for (int i = 0; i < 5; i++) begin
            xfer(8'h00, 1'b1, ctl[i]);
            tick(PERIOD + 2);
            s0 = cnt;
            commEvent <= 1'b1;
            tick(6);
            commEvent <= 1'b0;
            tick(10);
            diff();
            `CHK(d[0], ex[i])
            `CHK(d[3], ex[i])
            `CHK(d[4], 0)
        end
        $display("test edge done");
    endtask
    // Level held high while base A ends cycles: those reloads lose the qualifier
    task automatic testCoincide();
        xfer(8'h00, 1'b1, 32'h24);
        baseEn <= 3'h1;
        commEvent <= 1'b1;
        win(4 * PERIOD);
        commEvent <= 1'b0;
        baseEn <= 3'h0;
        `CHK(d[0], 4 * PERIOD)
        `CHK(d[3], 4 * PERIOD - 4)
        `CHK(d[4], 0)
        $display("test coincide done");
    endtask
    // Software settles the correction setup before values matter
    task automatic testPairs();
        logic [31:0] cor [0:2] = '{32'h0005, 32'h1500, 32'h2A00};
        logic [2:0]  sn [0:2] = '{3'h7, 3'h3, 3'h6};
        logic [2:0]  ex [0:2] = '{3'h5, 3'h4, 3'h1};
        logic [2:0]  u0;
        for (int i = 0; i < 3; i++) begin
            senseN <= sn[i];
            xfer(8'h04, 1'b1, cor[i]);
            tick(6);
            `CHK(useOdd, ex[i])
            xfer(8'h08, 1'b0, 32'h0);
            `CHK(rd[2:0], ex[i])
            `CHK(rd[5:3], sn[i])
        end
        xfer(8'h04, 1'b1, 32'h3F00);
        tick(6);
        u0 = useOdd;
        `CHK(u0, 3'h0)
        countDown <= 3'h2;
        tick(6);
        `CHK(useOdd ^ u0, 3'h2)
        $display("test pairs done");
    endtask
    // Reset for 8 cycles, then the scenarios
    initial begin
        repeat (8) @(posedge clk_sys);
        sys_rst <= 1'b0;
        testReset();
        testSource();
        testEdge();
        testCoincide();
        testPairs();
        summarize();
    end
endmodule
